// *** design/twms_slave.v ***
// two-wire slave port for an 8192 x 8 memory
// Summary of operation
// - ninth clock of each byte is acknowledge; transmitter releases, receiver pulls low
// - missing acknowledge aborts the operation and returns to idle
// - first byte after start is slave address: type, select pins, direction
// - direction bit one means read, zero means write
// - write sends two address bytes, high first; top three bits ignored
// - address latch increments after each data byte, before its acknowledge
// - latch wraps from last location to zero on reads and writes
// - latch holds between operations; reads start from held value
// - no limit on bytes per operation
// - read drives eight bits, samples master ack; ack continues, nack ends
// - write receives eight bits then acknowledges unless protected
// - all bytes shifted most significant bit first
// - written byte committed after eighth bit, before ack; no page buffer
// - no busy period after a write; next operation accepted at once
// - protect pin high: no store, no data ack, no latch increment
// - unconnected protect pin reads as low, unprotected
// - after read address, data shifts out from latch on next clock
// - read ends by nack then stop/start, or stop/start in ninth clock
// - selective read: write address bytes, repeated start, read address
// - stop is data rising while clock high; aborts any operation
// - start is data falling while clock high; aborts, expects slave address
// - sample on rising clock edge, change output after falling edge
// - data stable while clock high except start and stop
`include "twms_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module twms_slave #(
  parameter [3:0] DEV_TYPE = 4'hc, // arbitrary value
  parameter       AW       = `TWMS_ADDR_W
) (
  input  wire          core_clk_i,
  input  wire          nrst_i,
  input  wire          scl_i,
  input  wire          sda_i,
  output reg           sda_o,
  output reg           sda_oe_o,
  input  wire [2:0]    chip_select_pins_i,
  input  wire          wp_i,
  output reg  [AW-1:0] addr_latch_o,
  output reg           busy_o
);
  // reset release
  reg rst_s1_q;
  reg rst_n;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; scl and sda idle high on the bus
  reg  scl_s1_q;
  reg  scl_s2_q;
  reg  scl_s3_q;
  reg  sda_s1_q;
  reg  sda_s2_q;
  reg  sda_s3_q;
  reg  wp_s1_q;
  reg  wp_s2_q;
  reg  [2:0] sel_s1_q;
  reg  [2:0] sel_s2_q;
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      wp_s1_q  <= 1'b0;
      wp_s2_q  <= 1'b0;
      sel_s1_q <= 3'h0;
      sel_s2_q <= 3'h0;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      wp_s1_q  <= wp_i;
      wp_s2_q  <= wp_s1_q;
      sel_s1_q <= chip_select_pins_i;
      sel_s2_q <= sel_s1_q;
    end
  end
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  // data edges with clock held high are bus conditions
  wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  // protect input is pulled down at the pad, so an open pin synchronises as low
  wire protect = wp_s2_q;

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_DEV   = 7'h02;
  localparam [6:0] ST_AHI   = 7'h04;
  localparam [6:0] ST_ALO   = 7'h08;
  localparam [6:0] ST_WDATA = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_ACK   = 7'h40;

  reg [6:0]    state_q;
  reg [6:0]    next_q;     // state after the ack slot
  reg [3:0]    bit_q;      // 0..8, 8 = eighth bit taken, cleared to 0 as the ack slot opens
  reg [7:0]    sh_q;
  reg          dev_ack_q;  // device drives ack in this slot
  reg [7:0]    hi_q;
  reg [7:0]    mem_q [0:`TWMS_DEPTH-1];
  reg          wr_en;
  reg [7:0]    wr_byte;
  reg [AW-1:0] wr_addr;    // latch value before its increment

  ////////////////////////////////////////////////////////////////////////
  // write path: byte and its address queue up, drained one per clock,
  // so the store lands a few core clocks after the eighth bit, long
  // before the ack slot opens
  wire [AW+7:0] wq_data;
  wire          wq_valid;
  twms_fifo #(
    .WIDTH (AW+8),
    .DEPTH (`TWMS_FIFO_DEPTH),
    .AW    (3)
  ) u_wq (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n),
    .in_data_i   ({wr_addr, wr_byte}),
    .in_valid_i  (wr_en),
    .in_ready_o  (),
    .out_data_o  (wq_data),
    .out_valid_o (wq_valid),
    .out_ready_i (1'b1)
  );

  wire [7:0] rx_byte = {sh_q[6:0], sda_s2_q};
  wire       addr_ok = (rx_byte[`TWMS_TYPE_MSB:`TWMS_TYPE_LSB] == DEV_TYPE) &&
                       (rx_byte[`TWMS_SEL_MSB:`TWMS_SEL_LSB] == sel_s2_q);
  wire [AW-1:0] addr_inc = (addr_latch_o == `TWMS_LAST_ADDR) ? {AW{1'b0}} :
                           addr_latch_o + 1'b1;

  always @(posedge core_clk_i) begin
    // drain never stalls, so the queue cannot fill
    if (wq_valid) begin
      mem_q[wq_data[AW+7:8]] <= wq_data[7:0];
    end
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      next_q       <= ST_IDLE;
      bit_q        <= 4'h0;
      sh_q         <= 8'h00;
      dev_ack_q    <= 1'b0;
      hi_q         <= 8'h00;
      addr_latch_o <= {AW{1'b0}};
      sda_o        <= 1'b0;
      sda_oe_o     <= 1'b0;
      busy_o       <= 1'b0;
      wr_en        <= 1'b0;
      wr_byte      <= 8'h00;
      wr_addr      <= {AW{1'b0}};
    end else begin
      wr_en  <= 1'b0;
      busy_o <= (state_q != ST_IDLE);
      if (start_det) begin
        state_q  <= ST_DEV;
        bit_q    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        state_q  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (state_q == ST_IDLE) begin
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == ST_ACK) begin
          // master ack sampled only when the device was the transmitter
          if (!dev_ack_q && sda_s2_q) begin
            state_q <= ST_IDLE;
          end
        end else begin
          // transmit shifter advances on falling edges only
          if (state_q != ST_RDATA) begin
            sh_q <= rx_byte;
          end
          bit_q <= bit_q + 1'b1;
          if (bit_q == `TWMS_BITS_PER_BYTE - 1'b1) begin
            state_q   <= ST_ACK;
            dev_ack_q <= 1'b1;
            case (state_q)
              ST_DEV: begin
                if (!addr_ok) begin
                  state_q <= ST_IDLE;
                end else if (rx_byte[`TWMS_DIR_BIT] == `TWMS_DIR_READ) begin
                  next_q <= ST_RDATA;
                end else begin
                  next_q <= ST_AHI;
                end
              end
              ST_AHI: begin
                hi_q   <= rx_byte;
                next_q <= ST_ALO;
              end
              ST_ALO: begin
                addr_latch_o <= {hi_q[AW-9:0], rx_byte};
                next_q       <= ST_WDATA;
              end
              ST_WDATA: begin
                next_q <= ST_WDATA;
                if (protect) begin
                  dev_ack_q <= 1'b0;
                  state_q   <= ST_IDLE;
                end else begin
                  wr_en        <= 1'b1;
                  wr_byte      <= rx_byte;
                  wr_addr      <= addr_latch_o;
                  addr_latch_o <= addr_inc;
                end
              end
              ST_RDATA: begin
                dev_ack_q    <= 1'b0;
                next_q       <= ST_RDATA;
                addr_latch_o <= addr_inc;
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
      end else if (scl_fall) begin
        // drive changes follow the falling edge; start, stop and idle only release
        if (state_q == ST_ACK && bit_q == `TWMS_BITS_PER_BYTE) begin
          sda_o    <= 1'b0;
          sda_oe_o <= dev_ack_q;
          bit_q    <= 4'h0;
          sh_q     <= mem_q[addr_latch_o];
          if (!dev_ack_q) begin
            state_q <= ST_ACK;
          end
        end else if (state_q == ST_ACK) begin
          // end of ack slot
          state_q <= next_q;
          if (next_q == ST_RDATA) begin
            sh_q     <= {mem_q[addr_latch_o][6:0], 1'b0};
            sda_o    <= mem_q[addr_latch_o][7];
            sda_oe_o <= ~mem_q[addr_latch_o][7];
            bit_q    <= 4'h0;
          end else begin
            sda_oe_o <= 1'b0;
          end
        end else if (state_q == ST_RDATA) begin
          if (bit_q == `TWMS_BITS_PER_BYTE) begin
            sda_oe_o <= 1'b0; // release for master ack
            state_q  <= ST_ACK;
          end else begin
            // open drain: drive low only for a zero bit
            sda_o    <= sh_q[7];
            sda_oe_o <= ~sh_q[7];
            sh_q     <= {sh_q[6:0], 1'b0};
          end
        end else begin
          sda_oe_o <= 1'b0;
        end
      end
    end
  end
endmodule // twms_slave
`default_nettype wire

// *** include/twms_defs.vh ***
// constants for the two-wire memory slave port
`ifndef TWMS_DEFS_VH
`define TWMS_DEFS_VH
`define TWMS_ADDR_W        13
`define TWMS_DEPTH         8192
`define TWMS_LAST_ADDR     13'h1fff
`define TWMS_TYPE_MSB      7
`define TWMS_TYPE_LSB      4
`define TWMS_SEL_MSB       3
`define TWMS_SEL_LSB       1
`define TWMS_DIR_BIT       0
`define TWMS_DIR_READ      1'b1
`define TWMS_BITS_PER_BYTE 4'h8
`define TWMS_FIFO_DEPTH    8
`endif

// *** design/twms_fifo.v ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module twms_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  assign in_ready_o  = (cnt_q != DEPTH);
  assign out_valid_o = (cnt_q != 0);
  assign out_data_o  = mem_q[rp_q];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH-1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH-1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // twms_fifo
`default_nettype wire

// *** tb/twms_slave_props.sv ***
// assertions on the two-wire memory slave port pins
`timescale 1ns/100ps
`default_nettype none
module twms_slave_props #(
  parameter AW = 13
) (
  input wire logic          core_clk_i,
  input wire logic          nrst_i,
  input wire logic          scl_i,
  input wire logic          sda_i,
  input wire logic          sda_o,
  input wire logic          sda_oe_o,
  input wire logic [2:0]    chip_select_pins_i,
  input wire logic          wp_i,
  input wire logic [AW-1:0] addr_latch_o,
  input wire logic          busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("pin driven high");
  a_drive_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*4])
    else $error("drive too short");
  a_rise_clk_low: assert property ($rose(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("drive began with clock high");
  a_fall_clk_low: assert property ($fell(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("release with clock high");
  a_idle_quiet: assert property (!busy_o [*2] |-> !sda_oe_o)
    else $error("idle engine drives");
  a_latch_held: assert property (!busy_o && !$past(busy_o) |-> $stable(addr_latch_o))
    else $error("latch moved while idle");
  a_start_busy: assert property (scl_i && $fell(sda_i) |-> ##[1:8] busy_o)
    else $error("start ignored");
  a_stop_idle: assert property (scl_i && $rose(sda_i) |-> ##[1:8] !busy_o)
    else $error("stop ignored");
  cover property ($rose(sda_oe_o) && wp_i);
  cover property (scl_i && $fell(sda_i) && busy_o);
  cover property ($fell(busy_o));
endmodule // twms_slave_props
bind twms_slave twms_slave_props #(.AW(AW)) u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .chip_select_pins_i(chip_select_pins_i), .wp_i(wp_i),
  .addr_latch_o(addr_latch_o), .busy_o(busy_o));
`default_nettype wire

// *** tb/twms_master.sv ***
// two-wire bus master model, clock stands high outside frames
`timescale 1ns/100ps
`default_nettype none
module twms_master (
  output logic      scl_o,
  output logic      pull_o,
  input  wire logic sda_i
);
  localparam realtime Q = 31.25;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // release first so a repeated start is a real falling edge
  task automatic start_c;
    pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q pull_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  task automatic stop_c;
    pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q pull_o = 1'b0;
    #Q;
  endtask
  // ninth bit: 1 releases for the slave, 0 acks, final read byte nacked
  task automatic xfer(input logic [8:0] d, input int n, output logic [8:0] q);
    q = 9'h1ff;
    for (int i = 8; i > 8 - n; i--) begin // msb first
      pull_o = !d[i]; // changes only while clock low
      #Q scl_o = 1'b1;
      #Q q[i] = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
  endtask
endmodule // twms_master
`default_nettype wire

// *** tb/twms_slave_test.sv ***
// self-checking bench for the two-wire memory slave port
`timescale 1ns/100ps
`default_nettype none
module twms_slave_test;
  localparam [3:0] DT = 4'h6; // arbitrary type code
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wp = 1'b0;
  logic [2:0]  sel = 3'h5;
  logic [8:0]  q;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire         scl;
  wire         pull;
  wire         oe;
  wire         busy;
  wire  [12:0] alat;
  wire         sda = !(pull | oe); // pull-up when nobody pulls
  always #4 clk = !clk;
  twms_master m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  twms_slave #(.DEV_TYPE(DT)) uut (.core_clk_i(clk), .nrst_i(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(oe), .chip_select_pins_i(sel), .wp_i(wp),
    .addr_latch_o(alat), .busy_o(busy));
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic sb(input logic [7:0] b, input logic acked);
    m.xfer({b, 1'b1}, 9, q);
    chk({12'h0, q[0]}, {12'h0, !acked});
  endtask
  task automatic rb(input logic last, input logic [7:0] e);
    m.xfer({8'hff, last}, 9, q);
    chk({5'h0, q[8:1]}, {5'h0, e});
  endtask
  task automatic sa(input logic dir);
    sb({DT, sel, dir}, 1'b1);
  endtask
  task automatic seek(input logic [7:0] hi, input logic [7:0] lo);
    m.start_c();
    sa(1'b0);
    sb(hi, 1'b1);
    sb(lo, 1'b1);
  endtask
  task automatic t_write; // top address bits set but ignored
    seek(8'hff, 8'hff);
    sb(8'h3c, 1'b1);
    sb(8'hc3, 1'b1);
    sb(8'h5a, 1'b1);
    m.stop_c();
    chk(alat, 13'h0002);
    $display("write done");
  endtask
  task automatic t_sel_read; // no busy gap after a write
    seek(8'h1f, 8'hff);
    m.start_c();
    sa(1'b1);
    rb(1'b0, 8'h3c);
    rb(1'b0, 8'hc3);
    rb(1'b1, 8'h5a);
    m.stop_c();
    chk({12'h0, sda}, 13'h0001);
    chk(alat, 13'h0002);
    $display("selective read done");
  endtask
  task automatic t_protect;
    @(negedge clk) wp = 1'b1;
    seek(8'h00, 8'h00);
    sb(8'h99, 1'b0);
    m.stop_c();
    chk(alat, 13'h0000);
    @(negedge clk) wp = 1'b0;
    m.start_c();
    sa(1'b1);
    m.xfer(9'h1ff, 8, q); // stop lands in the ninth clock
    m.stop_c();
    chk({5'h0, q[8:1]}, 13'h00c3);
    $display("protect done");
  endtask
  task automatic t_abort;
    m.start_c();
    sb({DT, sel ^ 3'h1, 1'b0}, 1'b0);
    sb(8'h00, 1'b0);
    seek(8'h00, 8'h01);
    m.xfer(9'h000, 4, q); // byte cut short by a stop
    m.stop_c();
    m.start_c();
    sa(1'b1);
    rb(1'b1, 8'h5a);
    m.stop_c();
    $display("abort done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    t_write();
    t_sel_read();
    t_protect();
    t_abort();
    close_out();
  end
endmodule // twms_slave_test
`default_nettype wire
